// *** burner_field_model.sv ***
// Field side model: airflow, valve closure, firing-rate switches, flame
`timescale 1ns/1ps
module burner_field_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Commands from the controller
	input wire logic blower_out,
	input wire logic pilot_out,
	input wire logic upstream_main_valve,
	input wire logic downstream_main_valve,
	input wire logic fire_high_cmd,
	input wire logic fire_low_cmd,
	// Sensed contacts
	output logic lockout_interlock,
	output logic pre_ignition_interlock,
	output logic high_fire_sw,
	output logic low_fire_sw,
	output logic flame_present
);
	// Contacts as the field would close them, before the lag
	logic [4:0] cmd;
	logic [3:0][4:0] lag_r;
	assign cmd = {blower_out, !(upstream_main_valve || downstream_main_valve),
		pilot_out || upstream_main_valve || downstream_main_valve, fire_high_cmd, fire_low_cmd};

	// Five clocks of lag, so short steps still last long enough for a status poll
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lag_r <= '0;
			lockout_interlock <= 1'h0;
			pre_ignition_interlock <= 1'h0;
			high_fire_sw <= 1'h0;
			low_fire_sw <= 1'h0;
			flame_present <= 1'h0;
		end else begin
			lag_r <= {lag_r[2:0], cmd};
			lockout_interlock <= lag_r[3][4]; // Airflow proves only with the fan
			pre_ignition_interlock <= lag_r[3][3];
			flame_present <= lag_r[3][2];
			// End switches latch until the motor is driven the other way
			if (lag_r[3][1]) begin
				high_fire_sw <= 1'h1;
				low_fire_sw <= 1'h0;
			end else if (lag_r[3][0]) begin
				high_fire_sw <= 1'h0;
				low_fire_sw <= 1'h1;
			end
		end
	end
endmodule

// *** burner_pkg.sv ***
// Shared constants, types and register map of the burner sequencer
package burner_pkg;

	// Sequence states
	typedef enum logic [3:0] {
		S_INIT = 4'h0,
		S_HOLD = 4'h1,
		S_STBY = 4'h2,
		S_SHOLD = 4'h3,
		S_PURGE_HF = 4'h4,
		S_PURGE = 4'h5,
		S_PURGE_LF = 4'h6,
		S_PILOT = 4'h7,
		S_MAIN = 4'h8,
		S_RUN = 4'h9,
		S_POST = 4'hA,
		S_LOCK = 4'hB
	} seq_t;

	// Valve proving schedule codes
	localparam logic [2:0] VP_NEVER = 3'h0;
	localparam logic [2:0] VP_BEFORE = 3'h1;
	localparam logic [2:0] VP_AFTER = 3'h2;
	localparam logic [2:0] VP_BOTH = 3'h3;
	localparam logic [2:0] VP_SPLIT = 3'h4;

	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SCHED = 8'h04;
	localparam logic [7:0] A_PURGE = 8'h08;
	localparam logic [7:0] A_POST = 8'h0C;
	localparam logic [7:0] A_VPT = 8'h10;
	localparam logic [7:0] A_STAT = 8'h14;
	localparam logic [7:0] A_CMD = 8'h18;

	// Control field positions
	localparam int C_FULL = 0;
	localparam int C_PJ = 1;
	localparam int C_JA = 2;
	localparam int C_JB = 3;
	localparam int C_EXT = 4;

	// Reset values and the postpurge ceiling
	localparam logic [4:0] CTRL_RST = 5'h0C;
	localparam logic [2:0] SCHED_RST = 3'h0;
	localparam logic [3:0] PURGE_RST = 4'h0;
	localparam logic [11:0] POST_RST = 12'h00F;
	localparam logic [11:0] VPT_RST = 12'h00A;
	localparam logic [11:0] POST_MAX = 12'hF78;

	// One-second tick
	localparam int TICK_NS = 1000000000;
	localparam int CLK_NS = 8;
	localparam int TICK_CYC = TICK_NS / CLK_NS;

	// Sequence times in seconds
	localparam logic [11:0] T_INIT = 12'h00A;
	localparam logic [11:0] T_HOLD_MIN = 12'h005;
	localparam logic [11:0] T_HOLD_MAX = 12'h0F0;
	localparam logic [11:0] T_VP_START = 12'h00A;
	localparam logic [11:0] T_SHOLD = 12'h01E;
	localparam logic [3:0] T_INTLK = 4'hA;
	localparam logic [11:0] T_SPARK = 12'h005;
	localparam logic [11:0] T_PILOT_L = 12'h00A;
	localparam logic [11:0] T_PILOT_S = 12'h004;
	localparam logic [11:0] T_PILOT_OFF = 12'h00A;
	localparam logic [11:0] T_MAIN = 12'h00F;
	localparam logic [11:0] T_MAIN_EXT = 12'h01E;
	localparam logic [11:0] T_MAIN_VP = 12'h00A;
	localparam logic [11:0] T_DSI = 12'h004;
	localparam logic [11:0] T_STAB = 12'h00A;
	localparam logic [11:0] T_PII_POST = 12'h005;

	// Prepurge choices of the purge card, seconds
	localparam logic [11:0] PURGE_TAB [15] = '{
		12'h002, 12'h005, 12'h00A, 12'h00F, 12'h014,
		12'h01E, 12'h02D, 12'h03C, 12'h05A, 12'h078,
		12'h0B4, 12'h12C, 12'h258, 12'h384, 12'h708
	};

endpackage

// *** burner_sequence_controller.sv ***
// Burner sequencing state machine with APB register slave
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// - Ten second initiate before standby
// - Line fault holds; 5 s min, lockout 4 min
// - Standby waits demand with inputs correct
// - Prepurge blower, high fire, timing gated
// - Prepurge time from fifteen card choices
// - Proving runs with prepurge from 10 s
// - Pre-ignition open: hold 30 s or lockout
// - Interlock closed within 10 s of demand
// - Low fire, low-fire switch before ignition
// - Pilot, spark, intermittent; spark off 5 s
// - Flame by pilot period end, 10/4 s
// - Ignore pre-ignition; low-fire open locks out
// - Upstream valve on flame; pilot off 10 s
// - Intermittent pilot off timing by variant
// - Run after 15 s, or 30 s extended
// - Proving pilot: both valves, 15 s run
// - Direct spark: 4 s main trial then run
// - Proving without spark: 10 s main period
// - Ten second stabilization; run until demand drops
// - Postpurge blower, low fire, valves off
// - Pre-ignition closes within 5 s postpurge
// - Proving with postpurge, remainder completes
// - Five proving schedule choices
// - Both demands at once locks out
// - Proving demand with schedule never locks out
module burner_sequence_controller #(
	parameter int unsigned TICK_CYCLES = burner_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Burner inputs
	input wire logic line_ok,
	input wire logic demand_normal,
	input wire logic proving_demand_input,
	input wire logic lockout_interlock,
	input wire logic pre_ignition_interlock,
	input wire logic high_fire_sw,
	input wire logic low_fire_sw,
	input wire logic flame_present,
	// Burner outputs
	output logic blower_out,
	output logic ignition_out,
	output logic pilot_out,
	output logic intermittent_pilot_out,
	output logic upstream_main_valve,
	output logic downstream_main_valve,
	output logic fire_high_cmd,
	output logic fire_low_cmd,
	output logic modulate_out,
	output logic lockout_out
);

	typedef struct packed {
		burner_pkg::seq_t sq;
		logic [31:0] tcnt;
		logic tick;
		logic [11:0] sec;
		logic [3:0] dsec;
		logic [11:0] vsec;
		logic vp_run;
		logic vp_done;
		logic prove;
		logic mod;
		logic blower;
		logic ign;
		logic pilot;
		logic ipilot;
		logic mv_up;
		logic mv_dn;
		logic hi_cmd;
		logic lo_cmd;
		logic lock;
		logic [4:0] ctrl;
		logic [2:0] sched;
		logic [3:0] pcard;
		logic [11:0] post;
		logic [11:0] vpt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;

	state_t c;
	state_t n;

	// Purge card index to seconds; out-of-range picks the longest
	function automatic logic [11:0] purge_secs(input logic [3:0] idx);
		if (idx > 4'hE) begin
			return burner_pkg::PURGE_TAB[14];
		end
		return burner_pkg::PURGE_TAB[idx];
	endfunction

	// Address decode shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		return a == burner_pkg::A_CTRL || a == burner_pkg::A_SCHED ||
			a == burner_pkg::A_PURGE || a == burner_pkg::A_POST ||
			a == burner_pkg::A_VPT || a == burner_pkg::A_STAT ||
			a == burner_pkg::A_CMD;
	endfunction

	logic full;
	logic dsi;
	logic act_dem;
	logic vp_pre;
	logic vp_post;
	logic keep_ip;
	logic [11:0] run_t;
	logic [11:0] ip_t;
	logic [11:0] pp_t;
	logic wr;
	logic [7:0] a8;
	burner_pkg::seq_t ns;

	// Configuration decode
	always_comb begin
		full = c.ctrl[burner_pkg::C_FULL];
		dsi = full ? c.ctrl[burner_pkg::C_JA] : c.ctrl[burner_pkg::C_JB];
		pp_t = c.ctrl[burner_pkg::C_PJ] ? burner_pkg::T_PILOT_S : burner_pkg::T_PILOT_L;
		act_dem = c.prove ? proving_demand_input : demand_normal;
		vp_pre = c.sched == burner_pkg::VP_BEFORE || c.sched == burner_pkg::VP_BOTH ||
			c.sched == burner_pkg::VP_SPLIT;
		vp_post = c.sched == burner_pkg::VP_AFTER || c.sched == burner_pkg::VP_BOTH ||
			c.sched == burner_pkg::VP_SPLIT;
		keep_ip = !full && c.ctrl[burner_pkg::C_JA];
		ip_t = (!full && c.ctrl[burner_pkg::C_EXT]) ? burner_pkg::T_MAIN_EXT
			: burner_pkg::T_MAIN;
		run_t = (!full && c.ctrl[burner_pkg::C_EXT]) ? burner_pkg::T_MAIN_EXT
			: burner_pkg::T_MAIN;
		a8 = paddr[7:0];
		wr = psel && penable && c.pready && pwrite;
	end

	// Next-state logic: timers, sequence, outputs and registers
	always_comb begin
		n = c;
		ns = c.sq;
		// Common one-second tick for every sequence timer
		n.tick = 1'b0;
		n.tcnt = c.tcnt + 32'h1;
		if (c.tcnt >= TICK_CYCLES - 1) begin
			n.tcnt = 32'h0;
			n.tick = 1'b1;
		end
		if (c.tick && c.sec != 12'hFFF) begin
			n.sec = c.sec + 12'h1;
		end
		if (c.tick && c.dsec != 4'hF) begin
			n.dsec = c.dsec + 4'h1;
		end

		// Proving test: upstream valve first half, downstream second
		if (c.vp_run && c.tick) begin
			n.vsec = c.vsec + 12'h1;
		end
		if (c.vp_run && c.vsec >= c.vpt) begin
			n.vp_run = 1'b0;
			n.vp_done = 1'b1;
		end
		if (c.sq == burner_pkg::S_PURGE && c.prove && vp_pre && !c.vp_run &&
			!c.vp_done && c.sec >= burner_pkg::T_VP_START) begin
			n.vp_run = 1'b1;
			n.vsec = 12'h0;
		end

		case (c.sq)
			burner_pkg::S_INIT: begin
				if (!line_ok) begin
					ns = burner_pkg::S_HOLD;
				end else if (c.sec >= burner_pkg::T_INIT) begin
					ns = burner_pkg::S_STBY;
				end
			end
			burner_pkg::S_HOLD: begin
				if (c.sec >= burner_pkg::T_HOLD_MAX) begin
					ns = burner_pkg::S_LOCK;
				end else if (line_ok && c.sec >= burner_pkg::T_HOLD_MIN) begin
					ns = burner_pkg::S_INIT;
				end
			end
			burner_pkg::S_STBY: begin
				if ((demand_normal || proving_demand_input) &&
					pre_ignition_interlock && !flame_present) begin
					ns = burner_pkg::S_PURGE_HF;
					n.prove = proving_demand_input;
					n.dsec = 4'h0;
					n.vp_done = 1'b0;
				end
			end
			burner_pkg::S_SHOLD: begin
				if (c.sec >= burner_pkg::T_SHOLD) begin
					ns = burner_pkg::S_STBY;
				end
			end
			burner_pkg::S_PURGE_HF, burner_pkg::S_PURGE, burner_pkg::S_PURGE_LF: begin
				if (!act_dem) begin
					ns = burner_pkg::S_STBY;
				end else if (!pre_ignition_interlock && !c.vp_run) begin
					ns = full ? burner_pkg::S_LOCK : burner_pkg::S_SHOLD;
				end else if (c.sq != burner_pkg::S_PURGE_LF && !lockout_interlock &&
					c.dsec >= burner_pkg::T_INTLK) begin
					ns = full ? burner_pkg::S_LOCK : burner_pkg::S_PURGE_HF;
					n.dsec = 4'h0;
					n.sec = 12'h0;
				end else if (c.sq == burner_pkg::S_PURGE_HF) begin
					if (lockout_interlock && high_fire_sw) begin
						ns = burner_pkg::S_PURGE;
					end
				end else if (c.sq == burner_pkg::S_PURGE) begin
					// Proving must finish before the low-fire drive
					if (c.sec >= purge_secs(c.pcard) &&
						(!(c.prove && vp_pre) || c.vp_done)) begin
						ns = burner_pkg::S_PURGE_LF;
					end
				end else if (low_fire_sw) begin
					ns = (c.prove && dsi) ? burner_pkg::S_MAIN : burner_pkg::S_PILOT;
				end
			end
			burner_pkg::S_PILOT: begin
				if (!low_fire_sw) begin
					ns = burner_pkg::S_LOCK;
				end else if (c.sec >= pp_t) begin
					ns = flame_present ? burner_pkg::S_MAIN : burner_pkg::S_LOCK;
				end
			end
			burner_pkg::S_MAIN: begin
				if (!low_fire_sw) begin
					ns = burner_pkg::S_LOCK;
				end else if (c.prove && dsi) begin
					if (c.sec >= burner_pkg::T_DSI) begin
						ns = flame_present ? burner_pkg::S_RUN : burner_pkg::S_LOCK;
					end
				end else if (c.prove && c.sec >= burner_pkg::T_MAIN_VP && !flame_present) begin
					ns = burner_pkg::S_LOCK;
				end else if (c.sec >= (c.prove ? burner_pkg::T_MAIN : run_t)) begin
					ns = flame_present ? burner_pkg::S_RUN : burner_pkg::S_LOCK;
				end
			end
			burner_pkg::S_RUN: begin
				if (!flame_present) begin
					ns = burner_pkg::S_LOCK;
				end else if (!act_dem) begin
					ns = burner_pkg::S_POST;
					n.vp_done = 1'b0;
					if (c.prove && vp_post) begin
						n.vp_run = 1'b1;
						n.vsec = 12'h0;
					end
				end
			end
			burner_pkg::S_POST: begin
				if (!pre_ignition_interlock && !c.vp_run &&
					c.sec >= burner_pkg::T_PII_POST) begin
					ns = burner_pkg::S_LOCK;
				end else if (c.sec >= c.post && !c.vp_run) begin
					ns = burner_pkg::S_STBY;
				end
			end
			burner_pkg::S_LOCK: begin
				// Only a software reset leaves lockout
				if (wr && a8 == burner_pkg::A_CMD && pwdata[0]) begin
					ns = burner_pkg::S_INIT;
				end
			end
			default: ns = burner_pkg::S_LOCK;
		endcase

		// Line loss restarts initiate from any running state
		if (!line_ok && c.sq != burner_pkg::S_INIT && c.sq != burner_pkg::S_HOLD &&
			c.sq != burner_pkg::S_LOCK) begin
			ns = burner_pkg::S_INIT;
		end
		// Conflicting or unscheduled demand wins over everything outside lockout
		if (c.sq != burner_pkg::S_LOCK && ((demand_normal && proving_demand_input) ||
			(proving_demand_input && c.sched == burner_pkg::VP_NEVER))) begin
			ns = burner_pkg::S_LOCK;
		end
		if (ns != c.sq) begin
			n.sec = 12'h0;
		end
		if (ns == burner_pkg::S_LOCK || ns == burner_pkg::S_STBY ||
			ns == burner_pkg::S_INIT) begin
			n.vp_run = 1'b0;
		end
		n.sq = ns;
		n.lock = ns == burner_pkg::S_LOCK;

		// Outputs follow the next state so they change with it
		n.blower = ns inside {burner_pkg::S_PURGE_HF, burner_pkg::S_PURGE,
			burner_pkg::S_PURGE_LF, burner_pkg::S_PILOT, burner_pkg::S_MAIN,
			burner_pkg::S_RUN, burner_pkg::S_POST};
		n.hi_cmd = ns == burner_pkg::S_PURGE_HF || ns == burner_pkg::S_PURGE;
		n.lo_cmd = ns == burner_pkg::S_PURGE_LF || ns == burner_pkg::S_PILOT ||
			ns == burner_pkg::S_MAIN || ns == burner_pkg::S_POST ||
			(ns == burner_pkg::S_RUN && n.sec < burner_pkg::T_STAB);
		n.mod = ns == burner_pkg::S_RUN && n.sec >= burner_pkg::T_STAB;
		n.pilot = ns == burner_pkg::S_PILOT || (ns == burner_pkg::S_MAIN &&
			!(n.prove && dsi) && n.sec < burner_pkg::T_PILOT_OFF);
		n.ign = (ns == burner_pkg::S_PILOT && n.sec < burner_pkg::T_SPARK) ||
			(ns == burner_pkg::S_MAIN && n.prove && dsi);
		n.ipilot = !n.prove && (ns == burner_pkg::S_PILOT ||
			(ns == burner_pkg::S_MAIN && (keep_ip || n.sec < ip_t)) ||
			(ns == burner_pkg::S_RUN && keep_ip));
		n.mv_up = ns == burner_pkg::S_MAIN || ns == burner_pkg::S_RUN ||
			(n.vp_run && n.vsec < (c.vpt >> 1));
		n.mv_dn = ((ns == burner_pkg::S_MAIN || ns == burner_pkg::S_RUN) && n.prove) ||
			(n.vp_run && n.vsec >= (c.vpt >> 1));

		// APB: answer in the first access cycle, no wait states
		n.pready = psel && !penable;
		n.pslverr = psel && !penable && !mapped(a8);
		n.prdata = 32'h0;
		if (psel && !penable && !pwrite) begin
			case (a8)
				burner_pkg::A_CTRL: n.prdata = {27'h0, c.ctrl};
				burner_pkg::A_SCHED: n.prdata = {29'h0, c.sched};
				burner_pkg::A_PURGE: n.prdata = {28'h0, c.pcard};
				burner_pkg::A_POST: n.prdata = {20'h0, c.post};
				burner_pkg::A_VPT: n.prdata = {20'h0, c.vpt};
				burner_pkg::A_STAT: n.prdata = {16'h0, c.blower, c.ign, c.pilot,
					c.ipilot, c.mv_up, c.mv_dn, c.hi_cmd, c.lo_cmd,
					2'h0, c.mod, c.vp_run, c.sq};
				default: n.prdata = 32'h0;
			endcase
		end
		// Settings change only while idle so a running cycle stays coherent
		if (wr && (c.sq == burner_pkg::S_STBY || c.sq == burner_pkg::S_LOCK ||
			c.sq == burner_pkg::S_INIT)) begin
			case (a8)
				burner_pkg::A_CTRL: n.ctrl = pwdata[4:0];
				burner_pkg::A_SCHED: n.sched = (pwdata[2:0] > burner_pkg::VP_SPLIT)
					? burner_pkg::VP_NEVER : pwdata[2:0];
				burner_pkg::A_PURGE: n.pcard = pwdata[3:0];
				burner_pkg::A_POST: n.post = (pwdata[11:0] > burner_pkg::POST_MAX)
					? burner_pkg::POST_MAX : pwdata[11:0];
				burner_pkg::A_VPT: n.vpt = pwdata[11:0];
				default: n.ctrl = c.ctrl;
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c <= '0;
			c.sq <= burner_pkg::S_INIT;
			c.ctrl <= burner_pkg::CTRL_RST;
			c.sched <= burner_pkg::SCHED_RST;
			c.pcard <= burner_pkg::PURGE_RST;
			c.post <= burner_pkg::POST_RST;
			c.vpt <= burner_pkg::VPT_RST;
		end else begin
			c <= n;
		end
	end

	// Ports straight from the state flops
	assign prdata = c.prdata;
	assign pready = c.pready;
	assign pslverr = c.pslverr;
	assign blower_out = c.blower;
	assign ignition_out = c.ign;
	assign pilot_out = c.pilot;
	assign intermittent_pilot_out = c.ipilot;
	assign upstream_main_valve = c.mv_up;
	assign downstream_main_valve = c.mv_dn;
	assign fire_high_cmd = c.hi_cmd;
	assign fire_low_cmd = c.lo_cmd;
	assign modulate_out = c.mod;
	assign lockout_out = c.lock;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_init_len;
		c.sq == burner_pkg::S_STBY && $past(c.sq) == burner_pkg::S_INIT
			|-> $past(c.sec) >= burner_pkg::T_INIT;
	endproperty
	a_init_len: assert property (p_init_len) else $error("initiate too short");

	property p_hold_lock;
		c.sq == burner_pkg::S_HOLD && c.sec >= burner_pkg::T_HOLD_MAX |=> c.sq == burner_pkg::S_LOCK;
	endproperty
	a_hold_lock: assert property (p_hold_lock) else $error("hold did not lock");

	property p_purge_gate;
		c.sq == burner_pkg::S_PURGE && $past(c.sq) == burner_pkg::S_PURGE_HF
			|-> $past(lockout_interlock && high_fire_sw) && c.hi_cmd && c.blower;
	endproperty
	a_purge_gate: assert property (p_purge_gate) else $error("purge began ungated");

	property p_spark;
		c.sq == burner_pkg::S_PILOT && c.sec >= burner_pkg::T_SPARK |-> !c.ign;
	endproperty
	a_spark: assert property (p_spark) else $error("spark past five seconds");

	property p_pilot_flame;
		c.sq == burner_pkg::S_MAIN && $past(c.sq) == burner_pkg::S_PILOT |-> $past(flame_present);
	endproperty
	a_pilot_flame: assert property (p_pilot_flame) else $error("main without flame");

	property p_both_dem;
		c.sq != burner_pkg::S_LOCK && demand_normal && proving_demand_input
			|=> c.sq == burner_pkg::S_LOCK ##1 lockout_out;
	endproperty
	a_both_dem: assert property (p_both_dem) else $error("dual demand no lockout");

	property p_lock_safe;
		c.sq == burner_pkg::S_LOCK |-> !(c.ign || c.pilot || c.ipilot || c.mv_up || c.mv_dn);
	endproperty
	a_lock_safe: assert property (p_lock_safe) else $error("fuel on in lockout");

	property p_stab;
		c.sq == burner_pkg::S_RUN && c.sec < burner_pkg::T_STAB |-> !c.mod && c.lo_cmd;
	endproperty
	a_stab: assert property (p_stab) else $error("modulation too early");

	property p_post;
		c.sq == burner_pkg::S_POST && !c.vp_run |-> c.blower && c.lo_cmd && !c.mv_up && !c.ipilot;
	endproperty
	a_post: assert property (p_post) else $error("postpurge outputs wrong");

	property p_apb;
		psel && !penable |=> c.pready;
	endproperty
	a_apb: assert property (p_apb) else $error("no ready in access");

	c_run: cover property (c.sq == burner_pkg::S_RUN && c.mod);
	c_lock: cover property (c.sq == burner_pkg::S_LOCK);
	c_vp: cover property (c.vp_run && c.sq == burner_pkg::S_PURGE);
	c_post_done: cover property (c.sq == burner_pkg::S_STBY && $past(c.sq) == burner_pkg::S_POST);

endmodule

// *** tb_burner_sequence_controller.sv ***
// Self-checking bench for the burner sequencer
`timescale 1ns/1ps
module tb_burner_sequence_controller;
	localparam int TK = 16; // Clocks per simulated second, keeps runs short
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_ok, e;
	logic [31:0] paddr, pwdata, prdata, q;
	logic demand_normal, proving_demand_input, lockout_interlock, pre_ignition_interlock;
	logic high_fire_sw, low_fire_sw, flame_present, blower_out, ignition_out, pilot_out;
	logic intermittent_pilot_out, upstream_main_valve, downstream_main_valve;
	logic fire_high_cmd, fire_low_cmd, modulate_out, lockout_out;
	logic [7:0] outs;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	int t0, idx;
	// Expected walk of one firing cycle: state, outputs, care mask, seconds
	logic [3:0] st_w[7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
	logic [7:0] ou_w[7] = '{8'h82, 8'h82, 8'h81, 8'hF0, 8'hB8, 8'h88, 8'h81};
	logic [7:0] mk_w[7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'hFC, 8'hFC, 8'hFF};
	int sec_w[7] = '{0, 2, 0, 10, 15, 0, 3};
	// Register offsets and reset values
	logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [31:0] rv[5] = '{32'h0000000C, 32'h0, 32'h0, 32'h0000000F, 32'h0000000A};

	assign outs = {blower_out, ignition_out, pilot_out, intermittent_pilot_out,
		upstream_main_valve, downstream_main_valve, fire_high_cmd, fire_low_cmd};

	burner_sequence_controller #(.TICK_CYCLES(TK)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_ok(line_ok),
		.demand_normal(demand_normal), .proving_demand_input(proving_demand_input),
		.lockout_interlock(lockout_interlock), .pre_ignition_interlock(pre_ignition_interlock),
		.high_fire_sw(high_fire_sw), .low_fire_sw(low_fire_sw), .flame_present(flame_present),
		.blower_out(blower_out), .ignition_out(ignition_out), .pilot_out(pilot_out),
		.intermittent_pilot_out(intermittent_pilot_out),
		.upstream_main_valve(upstream_main_valve), .downstream_main_valve(downstream_main_valve),
		.fire_high_cmd(fire_high_cmd), .fire_low_cmd(fire_low_cmd),
		.modulate_out(modulate_out), .lockout_out(lockout_out));

	burner_field_model field (.pclk(pclk), .presetn(presetn), .blower_out(blower_out),
		.pilot_out(pilot_out), .upstream_main_valve(upstream_main_valve),
		.downstream_main_valve(downstream_main_valve), .fire_high_cmd(fire_high_cmd),
		.fire_low_cmd(fire_low_cmd), .lockout_interlock(lockout_interlock),
		.pre_ignition_interlock(pre_ignition_interlock), .high_fire_sw(high_fire_sw),
		.low_fire_sw(low_fire_sw), .flame_present(flame_present));

	// 125 MHz clock
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Hang guard, well above the longest expected run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			$display("[FAIL] run length expected below %0d seen %0d", 40000, cyc);
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, ex, got);
		end
	endtask

	// Seconds measured between polls, allowing for the early first tick
	task automatic chk_dur(input string n, input int s, input int c);
		chk(n, 32'h1, 32'(c > (s - 1) * TK - 8 && c <= s * TK + 8));
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the hang guard ends a wait for ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	// Poll the status word until the sequencer reaches a state
	task automatic wait_st(input logic [3:0] s);
		int n;
		n = 0;
		do begin
			apb(1'h0, 8'h14, 32'h0);
			n++;
		end while (q[3:0] !== s && n < 2000);
		chk("state", 32'(s), 32'(q[3:0]));
	endtask

	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		line_ok = 1'h1;
		demand_normal = 1'h0;
		proving_demand_input = 1'h0;
		void'($urandom(14652));
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		// Reset values, unmapped access, schedule codes, postpurge ceiling
		for (int i = 0; i < 5; i++) begin
			apb(1'h0, ra[i], 32'h0);
			chk("reset value", rv[i], q);
		end
		apb(1'h0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, 32'(e));
		for (int i = 0; i < 6; i++) begin
			apb(1'h1, 8'h04, 32'(i));
			apb(1'h0, 8'h04, 32'h0);
			chk("schedule", (i < 5) ? 32'(i) : 32'h0, q);
		end
		apb(1'h1, 8'h0C, 32'h00000FA0);
		apb(1'h0, 8'h0C, 32'h0);
		chk("postpurge max", 32'h00000F78, q);
		idx = $urandom_range(1, 0);
		sec_w[1] = idx ? 5 : 2;
		apb(1'h1, 8'h00, 32'h0000000D);
		apb(1'h1, 8'h08, 32'(idx));
		apb(1'h1, 8'h0C, 32'h00000003);
		$display("test registers done");
		// Line fault during initiate, then a full initiate
		line_ok <= 1'h0;
		wait_st(4'h1);
		t0 = cyc;
		line_ok <= 1'h1;
		wait_st(4'h0);
		chk("hold shown", 32'h1, 32'(cyc - t0 >= 4 * TK));
		t0 = cyc;
		wait_st(4'h2);
		chk_dur("initiate", 10, cyc - t0);
		$display("test initiate done");
		// Normal firing cycle on the main demand input
		demand_normal <= 1'h1;
		t0 = cyc;
		for (int i = 0; i < 7; i++) begin
			wait_st(st_w[i]);
			if (i > 0 && sec_w[i - 1] > 0) chk_dur("period", sec_w[i - 1], cyc - t0);
			t0 = cyc;
			chk("outputs", 32'(ou_w[i]), 32'(outs & mk_w[i]));
			if (i == 3) begin
				repeat (3 * TK) @(posedge pclk);
				chk("spark early", 32'h1, 32'(ignition_out));
				repeat (3 * TK) @(posedge pclk);
				chk("spark off", 32'h000000B0, 32'(outs & 8'hFC));
			end
			if (i == 5) begin
				repeat (8 * TK) @(posedge pclk);
				chk("modulate early", 32'h0, 32'(modulate_out));
				repeat (4 * TK) @(posedge pclk);
				chk("modulate", 32'h1, 32'(modulate_out));
				demand_normal <= 1'h0;
			end
		end
		wait_st(4'h2);
		chk_dur("postpurge", sec_w[6], cyc - t0);
		$display("test firing done");
		// Miswired demand: both inputs, then proving with no schedule
		for (int k = 0; k < 2; k++) begin
			repeat ($urandom_range(8, 1)) @(posedge pclk);
			demand_normal <= (k == 0);
			proving_demand_input <= 1'h1;
			wait_st(4'hB);
			chk("fuel off", 32'h0, 32'(outs & 8'h7C));
			demand_normal <= 1'h0;
			proving_demand_input <= 1'h0;
			repeat (4 * TK) @(posedge pclk);
			chk("latched", 32'h1, 32'(lockout_out));
			apb(1'h1, 8'h18, 32'h1);
			wait_st(4'h0);
			wait_st(4'h2);
			$display("test lockout %0d done", k);
		end
		// Line fault that outlasts the hold limit
		line_ok <= 1'h0;
		wait_st(4'h1);
		t0 = cyc;
		wait_st(4'hB);
		chk_dur("hold limit", 240, cyc - t0);
		chk("hold lockout", 32'h1, 32'(lockout_out));
		$display("test hold limit done");
		finish_test();
	end
endmodule
